/* File: pkg/srl_pkg.sv */
// Constants and types for the system register write lock
//
// Contract
// - Unlock only after key one then key two written back to back.
// - Stay unlocked until the key register gets a non-key value.
// - Any write elsewhere between the two keys cancels the attempt.
// - Key register reads 0 while locked, 1 while unlocked.
// - Lock guards the eight system control registers listed below.
// - Locked writes to guarded registers are dropped and flagged by a one-cycle write_dropped_out pulse.
`default_nettype none

package srl_pkg;

	localparam int          ADDR_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          NUM_PROT  = 8;

	localparam logic [31:0] KEY_FIRST  = 32'haa99_6655;
	localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;

	// Register map, byte addresses on the plain register port
	localparam logic [7:0]  SYSTEM_UNLOCK_KEY_REG      = 8'h00;
	localparam logic [7:0]  PROT_BASE                  = 8'h10;
	localparam logic [7:0]  OSCILLATOR_CONTROL_REG     = 8'h10;
	localparam logic [7:0]  SYSTEM_PLL_CONTROL_REG     = 8'h14;
	localparam logic [7:0]  FAST_RC_TUNING_REG         = 8'h18;
	localparam logic [7:0]  MODULE_DISABLE_CONTROL_REG = 8'h1c;
	localparam logic [7:0]  SOFTWARE_RESET_REG         = 8'h20;
	localparam logic [7:0]  PIN_SELECT_CONFIG_REG      = 8'h24;
	localparam logic [7:0]  SLEEP_POWER_CONTROL_REG    = 8'h28;
	localparam logic [7:0]  CALENDAR_CONTROL_REG       = 8'h2c;
	localparam logic [7:0]  PROT_LAST                  = 8'h2c;

	localparam logic [31:0] PROT_RESET_VAL = 32'h0000_0000;
	localparam int          LOCK_BIT       = 0;

	typedef enum logic [2:0] {
		SRL_LOCKED    = 3'b001,
		SRL_KEY1_SEEN = 3'b010,
		SRL_UNLOCKED  = 3'b100
	} srl_state_t;

endpackage : srl_pkg

`default_nettype wire

/* File: rtl/srl_prot_reg.sv */
// One guarded 32-bit system control register
`default_nettype none

module srl_prot_reg
	import srl_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	input  wire logic              wr_en_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	output var  logic [DATA_W-1:0] value_out
);

	logic [DATA_W-1:0] value;
	logic [DATA_W-1:0] next_value;

	always_comb begin
		next_value = value;
		if (wr_en_in) begin
			next_value = wdata_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			value <= PROT_RESET_VAL;
		end else begin
			value <= next_value;
		end
	end

	assign value_out = value;

endmodule // srl_prot_reg

`default_nettype wire

/* File: rtl/srl_lock.sv */
// System register write lock with key sequence and guarded registers
`default_nettype none

module srl_lock
	import srl_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output var  logic [DATA_W-1:0] rdata_out,
	output var  logic              unlocked_out,
	output var  logic [DATA_W-1:0] prot_value_out [NUM_PROT],
	output var  logic              write_dropped_out
);

	function automatic logic is_prot(input logic [ADDR_W-1:0] a);
		return (a >= PROT_BASE) && (a <= PROT_LAST) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [2:0] prot_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - PROT_BASE;
		return off[4:2];
	endfunction

	srl_state_t        state;
	srl_state_t        next_state;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic              dropped;
	logic              next_dropped;
	logic              key_wr;
	logic              prot_wr;
	logic              is_key_val;

	assign key_wr     = wr_in && (addr_in == SYSTEM_UNLOCK_KEY_REG);
	assign prot_wr    = wr_in && is_prot(addr_in);
	assign is_key_val = (wdata_in == KEY_FIRST) || (wdata_in == KEY_SECOND);

	// Key sequence tracker
	always_comb begin
		next_state = state;
		case (state)
			SRL_LOCKED: begin
				if (key_wr && wdata_in == KEY_FIRST) begin
					next_state = SRL_KEY1_SEEN;
				end
			end
			SRL_KEY1_SEEN: begin
				if (key_wr) begin
					if (wdata_in == KEY_SECOND) begin
						next_state = SRL_UNLOCKED;
					end else if (wdata_in == KEY_FIRST) begin
						next_state = SRL_KEY1_SEEN;
					end else begin
						next_state = SRL_LOCKED;
					end
				end else if (wr_in) begin
					next_state = SRL_LOCKED;
				end
			end
			SRL_UNLOCKED: begin
				// Repeating a key while open keeps it open, so retry loops are harmless
				if (key_wr && !is_key_val) begin
					next_state = SRL_LOCKED;
				end
			end
			default: begin
				next_state = SRL_LOCKED;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state <= SRL_LOCKED;
		end else begin
			state <= next_state;
		end
	end

	// Guarded registers take writes only while open
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PROT; gi++) begin : g_prot
			logic wr_en;
			assign wr_en = prot_wr && (prot_index(addr_in) == 3'(gi))
				&& (state == SRL_UNLOCKED);
			srl_prot_reg u_reg (
				.mclk_in   (mclk_in),
				.rst_in    (rst_in),
				.wr_en_in  (wr_en),
				.wdata_in  (wdata_in),
				.value_out (prot_value_out[gi])
			);
		end
	endgenerate

	// Read data and drop indicator; unmapped reads return zero, data only after a read
	always_comb begin
		next_rdata   = '0;
		next_dropped = prot_wr && (state != SRL_UNLOCKED);
		if (rd_in) begin
			if (addr_in == SYSTEM_UNLOCK_KEY_REG) begin
				next_rdata[LOCK_BIT] = (state == SRL_UNLOCKED);
			end else if (is_prot(addr_in)) begin
				next_rdata = prot_value_out[prot_index(addr_in)];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rdata   <= '0;
			dropped <= 1'b0;
		end else begin
			rdata   <= next_rdata;
			dropped <= next_dropped;
		end
	end

	assign rdata_out         = rdata;
	assign write_dropped_out = dropped;
	assign unlocked_out      = (state == SRL_UNLOCKED);

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_key_pair_unlocks: assert property (
		(state == SRL_LOCKED && key_wr && wdata_in == KEY_FIRST)
		##1 (key_wr && wdata_in == KEY_SECOND) |=> unlocked_out
	) else $error("key pair did not unlock");

	a_no_single_unlock: assert property (
		(state == SRL_LOCKED) |=> !unlocked_out
	) else $error("unlocked without two keys");

	a_nonkey_relocks: assert property (
		(unlocked_out && key_wr && !is_key_val) |=> (state == SRL_LOCKED)
	) else $error("non-key write did not relock");

	a_stays_open: assert property (
		(unlocked_out && !(key_wr && !is_key_val)) |=> unlocked_out
	) else $error("lock closed without non-key write");

	a_other_write_aborts: assert property (
		(state == SRL_KEY1_SEEN && wr_in && !key_wr)
		##1 (key_wr && wdata_in == KEY_SECOND) |=> !unlocked_out
	) else $error("interrupted sequence still unlocked");

	a_status_read: assert property (
		(rd_in && addr_in == SYSTEM_UNLOCK_KEY_REG)
		|=> (rdata_out == {31'h0, $past(unlocked_out)})
	) else $error("key register read shows wrong lock state");

	a_drop_flag: assert property (
		(prot_wr && !unlocked_out) |=> write_dropped_out
	) else $error("locked write not flagged as dropped");

	// Pulse must drop again, or software would see stale drops
	a_drop_pulse: assert property (
		!(prot_wr && !unlocked_out) |=> !write_dropped_out
	) else $error("drop flag without locked guarded write");

	a_key1_restart: assert property (
		(state == SRL_KEY1_SEEN && key_wr && wdata_in == KEY_FIRST)
		|=> (state == SRL_KEY1_SEEN)
	) else $error("repeated first key lost the sequence");

	a_bad_second: assert property (
		(state == SRL_KEY1_SEEN && key_wr && !is_key_val) |=> (state == SRL_LOCKED)
	) else $error("wrong second key did not cancel");

	// Reads never move the sequencer, so polling between keys is safe
	a_read_keeps: assert property (
		(state == SRL_KEY1_SEEN && !wr_in) |=> (state == SRL_KEY1_SEEN)
	) else $error("sequence lost without a write");

	a_rdata_idle: assert property (
		!rd_in |=> (rdata_out == '0)
	) else $error("read data without a read");

	a_unmapped_read: assert property (
		(rd_in && addr_in != SYSTEM_UNLOCK_KEY_REG && !is_prot(addr_in))
		|=> (rdata_out == '0)
	) else $error("unmapped read not zero");

	generate
		for (gi = 0; gi < NUM_PROT; gi++) begin : g_chk
			// Judged from the bus, not from wr_en, so a broken gate is caught
			a_locked_hold: assert property (
				!(prot_wr && unlocked_out && prot_index(addr_in) == 3'(gi))
				|=> $stable(prot_value_out[gi])
			) else $error("guarded register changed without open write");

			a_open_write: assert property (
				(prot_wr && unlocked_out && prot_index(addr_in) == 3'(gi))
				|=> (prot_value_out[gi] == $past(wdata_in))
			) else $error("open write not stored");

			a_guard_read: assert property (
				(rd_in && is_prot(addr_in) && prot_index(addr_in) == 3'(gi))
				|=> (rdata_out == $past(prot_value_out[gi]))
			) else $error("guarded read returned wrong value");
		end
	endgenerate

	a_reset_locks: assert property (
		@(posedge mclk_in) disable iff (1'b0) rst_in |=> (state == SRL_LOCKED)
	) else $error("reset did not relock");

	c_unlock: cover property (state == SRL_KEY1_SEEN ##1 unlocked_out);
	c_abort: cover property (state == SRL_KEY1_SEEN && wr_in && !key_wr);
	c_relock: cover property (unlocked_out ##1 !unlocked_out);
	c_dropped: cover property (write_dropped_out);
	c_restart: cover property (state == SRL_KEY1_SEEN && key_wr && wdata_in == KEY_FIRST);

endmodule // srl_lock

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the system register write lock
`default_nettype none

module tb_top
	import srl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              mclk_in  = 1'b0;
	logic              rst_in   = 1'b1;
	logic [ADDR_W-1:0] addr_in  = 8'h00;
	logic [DATA_W-1:0] wdata_in = 32'h0000_0000;
	logic              wr_in    = 1'b0;
	logic              rd_in    = 1'b0;
	logic [DATA_W-1:0] rdata_out;
	logic              unlocked_out;
	logic [DATA_W-1:0] prot_value_out [NUM_PROT];
	logic              write_dropped_out;
	int                n_mismatch = 0;
	int                cmp_count  = 0;
	int                cyc        = 0;

	always #5 mclk_in = ~mclk_in;

	srl_lock srl_lock_inst (
		.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .unlocked_out(unlocked_out),
		.prot_value_out(prot_value_out), .write_dropped_out(write_dropped_out)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task flag(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	// Strobe stays up so back-to-back writes never assign twice in one step
	task wr(input logic [7:0] a, input logic [31:0] d);
		wr_in <= 1'b1;
		rd_in <= 1'b0;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		#1;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		rd_in <= 1'b1;
		wr_in <= 1'b0;
		addr_in <= a;
		@(posedge mclk_in);
		#1;
		chk(rdata_out, exp);
		rd_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		chk(rdata_out, 32'h0000_0000);
	endtask

	task do_reset;
		rst_in <= 1'b1;
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		repeat (8) @(posedge mclk_in);
		#1;
		rst_in <= 1'b0;
	endtask

	task t_locked;
		for (int i = 0; i < NUM_PROT; i++) begin
			wr(PROT_BASE + 8'(i * 4), 32'h1234_5678);
			flag(write_dropped_out, 1'b1);
		end
		rd(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		for (int i = 0; i < NUM_PROT; i++)
			chk(prot_value_out[i], 32'h0000_0000);
		$display("locked writes done");
	endtask

	task t_unlock;
		wr(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		flag(unlocked_out, 1'b0);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b1);
		rd(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0001);
		for (int i = 0; i < NUM_PROT; i++) begin
			wr(PROT_BASE + 8'(i * 4), 32'ha5a5_0000 | 32'(i));
			flag(write_dropped_out, 1'b0);
		end
		for (int i = 0; i < NUM_PROT; i++)
			chk(prot_value_out[i], 32'ha5a5_0000 | 32'(i));
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b1);
		wr(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		flag(unlocked_out, 1'b0);
		wr(OSCILLATOR_CONTROL_REG, 32'hffff_ffff);
		chk(prot_value_out[0], 32'ha5a5_0000);
		rd(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		rd(OSCILLATOR_CONTROL_REG, 32'ha5a5_0000);
		$display("unlock done");
	endtask

	task t_abort;
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		wr(FAST_RC_TUNING_REG, 32'h0000_0001);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b0);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		wr(8'h80, 32'h0000_0001);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b0);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		wr(SYSTEM_UNLOCK_KEY_REG, 32'h1234_5678);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b0);
		// A status read between the keys must not break the pair
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		rd(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b1);
		wr(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0000);
		flag(unlocked_out, 1'b0);
		// Retry of the pair, as software does with DMA left running
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		rd(SYSTEM_UNLOCK_KEY_REG, 32'h0000_0001);
		$display("abort done");
	endtask

	task t_reset;
		wr(CALENDAR_CONTROL_REG, 32'h0000_00c3);
		chk(prot_value_out[7], 32'h0000_00c3);
		do_reset();
		flag(unlocked_out, 1'b0);
		chk(prot_value_out[7], 32'h0000_0000);
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_FIRST);
		do_reset();
		wr(SYSTEM_UNLOCK_KEY_REG, KEY_SECOND);
		flag(unlocked_out, 1'b0);
		$display("reset done");
	endtask

	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Tests need about 80 cycles
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	initial begin
		do_reset();
		t_locked();
		t_unlock();
		t_abort();
		t_reset();
		print_verdict();
	end

endmodule // tb_top

`default_nettype wire
